// File: rtl/tcu_compare_unit.sv
// Timer counter with one compare channel, waveform output and pin override.
// Assumes timer_tick is a one-cycle enable on clk from clock-select logic,
// and that irq acknowledge pulses come from the interrupt controller.
//
// Decided for this implementation: strobed register access and the register addresses.
module tcu_compare_unit (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Register port
  input wire logic [tcu_pkg::ADDR_W-1:0] addr,
  input wire logic [tcu_pkg::DATA_W-1:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [tcu_pkg::DATA_W-1:0] rdata,
  // Timer clock enable
  input wire logic timer_tick,
  // Interrupt side
  input wire logic global_irq_enable,
  input wire logic compare_irq_ack,
  input wire logic overflow_irq_ack,
  output logic compare_irq_req,
  output logic overflow_irq_req,
  // Compare output pin
  output logic pin_out,
  output logic pin_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [7:0] counter_value_r;
  logic [7:0] compare_value_r;
  logic [7:0] compare_buf_r;
  tcu_pkg::tcu_ctrl_s ctrl_r;
  logic count_down_r;
  logic block_r;
  logic compare_output_r;
  logic compare_flag_r;
  logic overflow_flag_r;
  logic compare_irq_enable_r;
  logic overflow_irq_enable_r;
  logic port_value_r;
  logic compare_pin_direction_bit_r;
  logic [7:0] rdata_r;

  logic [7:0] counter_nxt;
  logic count_down_nxt;
  logic match;
  logic is_pwm;
  logic wr_counter;
  logic wr_compare;
  logic wr_control;
  logic wr_flags;
  logic force_compare_strobe;
  logic load_buffer;
  logic overflow_event;
  logic oc_nxt;
  logic act_noninv;
  tcu_pkg::tcu_ctrl_s ctrl_wr;

  assign is_pwm = (ctrl_r.mode == tcu_pkg::MODE_PHASE_PWM) ||
                  (ctrl_r.mode == tcu_pkg::MODE_FAST_PWM);
  assign wr_counter = wr_stb && (addr == tcu_pkg::OFS_COUNTER);
  assign wr_compare = wr_stb && (addr == tcu_pkg::OFS_COMPARE);
  assign wr_control = wr_stb && (addr == tcu_pkg::OFS_CONTROL);
  assign wr_flags = wr_stb && (addr == tcu_pkg::OFS_FLAGS);
  // Strobe is not stored; the mode and action written with it decide it
  assign ctrl_wr = tcu_pkg::tcu_ctrl_s'({wdata[tcu_pkg::CTL_ACT_LSB +: 2],
                                         wdata[tcu_pkg::CTL_MODE_LSB +: 2]});
  assign force_compare_strobe = wr_control && wdata[tcu_pkg::CTL_FORCE_BIT] &&
    (ctrl_wr.mode == tcu_pkg::MODE_NORMAL ||
     ctrl_wr.mode == tcu_pkg::MODE_CLEAR_ON_MATCH);

  // Equality is live; a counter write blanks it for one timer tick
  assign match = (counter_value_r == compare_value_r) && !block_r;

  ////////////////////////////////////////////////////////////////////////////
  // Counter sequencing, chosen by mode only
  always_comb begin
    counter_nxt = counter_value_r + tcu_pkg::CNT_STEP;
    count_down_nxt = count_down_r;
    unique case (ctrl_r.mode)
      tcu_pkg::MODE_NORMAL: begin
        count_down_nxt = 1'b0;
      end
      tcu_pkg::MODE_CLEAR_ON_MATCH: begin
        count_down_nxt = 1'b0;
        if (match) begin
          counter_nxt = tcu_pkg::CNT_BOTTOM;
        end
      end
      tcu_pkg::MODE_FAST_PWM: begin
        count_down_nxt = 1'b0;
        if (counter_value_r == tcu_pkg::CNT_MAX) begin
          counter_nxt = tcu_pkg::CNT_BOTTOM;
        end
      end
      tcu_pkg::MODE_PHASE_PWM: begin
        if (counter_value_r == tcu_pkg::CNT_MAX) begin
          count_down_nxt = 1'b1;
        end else if (counter_value_r == tcu_pkg::CNT_BOTTOM) begin
          count_down_nxt = 1'b0;
        end
        if (count_down_nxt) begin
          counter_nxt = counter_value_r - tcu_pkg::CNT_STEP;
        end else begin
          counter_nxt = counter_value_r + tcu_pkg::CNT_STEP;
        end
      end
    endcase
  end

  // Overflow point differs per mode
  always_comb begin
    unique case (ctrl_r.mode)
      tcu_pkg::MODE_FAST_PWM:
        overflow_event = counter_nxt == tcu_pkg::CNT_MAX;
      tcu_pkg::MODE_PHASE_PWM:
        overflow_event = (counter_nxt == tcu_pkg::CNT_BOTTOM) &&
                         count_down_nxt;
      default:
        overflow_event = (counter_value_r == tcu_pkg::CNT_MAX) &&
                         (counter_nxt == tcu_pkg::CNT_BOTTOM);
    endcase
  end

  // CPU write beats any count or clear, even with the timer stopped
  always_ff @(posedge clk) begin
    if (srst) begin
      counter_value_r <= tcu_pkg::REG_RESET;
      count_down_r <= 1'b0;
    end else if (wr_counter) begin
      counter_value_r <= wdata;
    end else if (timer_tick) begin
      counter_value_r <= counter_nxt;
      count_down_r <= count_down_nxt;
    end
  end

  // Blocking window lasts until the next timer tick
  always_ff @(posedge clk) begin
    if (srst) begin
      block_r <= 1'b0;
    end else if (wr_counter) begin
      block_r <= 1'b1;
    end else if (timer_tick) begin
      block_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare value: buffered in PWM, direct otherwise
  // Fast PWM loads at the MAX-to-BOTTOM turn, phase PWM at top
  assign load_buffer = timer_tick && is_pwm && !wr_counter &&
                       (counter_value_r == tcu_pkg::CNT_MAX);

  always_ff @(posedge clk) begin
    if (srst) begin
      compare_buf_r <= tcu_pkg::REG_RESET;
    end else if (wr_compare) begin
      compare_buf_r <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      compare_value_r <= tcu_pkg::REG_RESET;
    end else if (wr_compare && !is_pwm) begin
      compare_value_r <= wdata;
    end else if (load_buffer) begin
      compare_value_r <= compare_buf_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control, enables and pin register
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_r <= tcu_pkg::CTRL_RESET;
    end else if (wr_control) begin
      // Takes effect at once; only the compare value is buffered
      ctrl_r <= ctrl_wr;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      compare_irq_enable_r <= 1'b0;
      overflow_irq_enable_r <= 1'b0;
    end else if (wr_stb && (addr == tcu_pkg::OFS_IRQ_EN)) begin
      compare_irq_enable_r <= wdata[tcu_pkg::FLG_CMP_BIT];
      overflow_irq_enable_r <= wdata[tcu_pkg::FLG_OVF_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      port_value_r <= 1'b0;
      compare_pin_direction_bit_r <= 1'b0;
    end else if (wr_stb && (addr == tcu_pkg::OFS_PIN)) begin
      port_value_r <= wdata[tcu_pkg::PIN_PORT_BIT];
      compare_pin_direction_bit_r <= wdata[tcu_pkg::PIN_DIR_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags: hardware set wins over any clear in the same cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      compare_flag_r <= 1'b0;
    end else if (timer_tick && match && !wr_counter) begin
      compare_flag_r <= 1'b1;
    end else if (compare_irq_ack) begin
      compare_flag_r <= 1'b0;
    end else if (wr_flags && wdata[tcu_pkg::FLG_CMP_BIT]) begin
      compare_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      overflow_flag_r <= 1'b0;
    end else if (timer_tick && overflow_event && !wr_counter) begin
      overflow_flag_r <= 1'b1;
    end else if (overflow_irq_ack) begin
      overflow_flag_r <= 1'b0;
    end else if (wr_flags && wdata[tcu_pkg::FLG_OVF_BIT]) begin
      overflow_flag_r <= 1'b0;
    end
  end

  assign compare_irq_req = compare_flag_r && compare_irq_enable_r &&
                           global_irq_enable;
  assign overflow_irq_req = overflow_flag_r && overflow_irq_enable_r &&
                            global_irq_enable;

  ////////////////////////////////////////////////////////////////////////////
  // Waveform generator
  assign act_noninv = ctrl_r.action == tcu_pkg::ACT_CLEAR;

  always_comb begin
    oc_nxt = compare_output_r;
    if (ctrl_r.action != tcu_pkg::ACT_NONE) begin
      unique case (ctrl_r.mode)
        tcu_pkg::MODE_NORMAL, tcu_pkg::MODE_CLEAR_ON_MATCH: begin
          if (ctrl_r.action == tcu_pkg::ACT_TOGGLE) begin
            oc_nxt = !compare_output_r;
          end else begin
            oc_nxt = ctrl_r.action == tcu_pkg::ACT_SET;
          end
        end
        tcu_pkg::MODE_FAST_PWM: begin
          if (ctrl_r.action == tcu_pkg::ACT_TOGGLE) begin
            oc_nxt = match ? !compare_output_r : compare_output_r;
          end else if (counter_value_r == tcu_pkg::CNT_MAX) begin
            // Bottom edge wins, so compare at MAX gives a steady level
            oc_nxt = act_noninv;
          end else if (match) begin
            oc_nxt = !act_noninv;
          end
        end
        tcu_pkg::MODE_PHASE_PWM: begin
          // At MAX the slope turns down, at BOTTOM it turns up
          if (match && ctrl_r.action != tcu_pkg::ACT_TOGGLE) begin
            oc_nxt = count_down_nxt ? act_noninv : !act_noninv;
          end
        end
      endcase
    end
  end

  // Mode changes do not touch this register
  always_ff @(posedge clk) begin
    if (srst) begin
      compare_output_r <= 1'b0;
    end else if (force_compare_strobe &&
                 ctrl_wr.action != tcu_pkg::ACT_NONE) begin
      if (ctrl_wr.action == tcu_pkg::ACT_TOGGLE) begin
        compare_output_r <= !compare_output_r;
      end else begin
        compare_output_r <= ctrl_wr.action == tcu_pkg::ACT_SET;
      end
    end else if (timer_tick && !wr_counter && (match || is_pwm)) begin
      compare_output_r <= oc_nxt;
    end
  end

  // Direction bit alone decides whether the pin drives
  assign pin_out = (ctrl_r.action != tcu_pkg::ACT_NONE) ?
                   compare_output_r : port_value_r;
  assign pin_oe = compare_pin_direction_bit_r;

  ////////////////////////////////////////////////////////////////////////////
  // Read port: data one cycle after the strobe, zero otherwise
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_r <= tcu_pkg::REG_RESET;
    end else if (rd_stb) begin
      rdata_r <= tcu_pkg::REG_RESET;
      unique case (addr)
        tcu_pkg::OFS_COUNTER: rdata_r <= counter_value_r;
        tcu_pkg::OFS_COMPARE:
          rdata_r <= is_pwm ? compare_buf_r : compare_value_r;
        tcu_pkg::OFS_CONTROL: begin
          rdata_r[tcu_pkg::CTL_MODE_LSB +: 2] <= ctrl_r.mode;
          rdata_r[tcu_pkg::CTL_ACT_LSB +: 2] <= ctrl_r.action;
        end
        tcu_pkg::OFS_FLAGS: begin
          rdata_r[tcu_pkg::FLG_CMP_BIT] <= compare_flag_r;
          rdata_r[tcu_pkg::FLG_OVF_BIT] <= overflow_flag_r;
        end
        tcu_pkg::OFS_IRQ_EN: begin
          rdata_r[tcu_pkg::FLG_CMP_BIT] <= compare_irq_enable_r;
          rdata_r[tcu_pkg::FLG_OVF_BIT] <= overflow_irq_enable_r;
        end
        tcu_pkg::OFS_PIN: begin
          rdata_r[tcu_pkg::PIN_PORT_BIT] <= port_value_r;
          rdata_r[tcu_pkg::PIN_DIR_BIT] <= compare_pin_direction_bit_r;
        end
        default: rdata_r <= tcu_pkg::REG_RESET;
      endcase
    end else begin
      rdata_r <= tcu_pkg::REG_RESET;
    end
  end

  assign rdata = rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_flag_after_match;
    @(posedge clk) disable iff (srst)
      timer_tick && match && !wr_counter |=> compare_flag_r;
  endproperty
  a_flag_after_match: assert property (p_flag_after_match)
    else $error("compare flag not set after match");
  property p_irq_gate;
    @(posedge clk) disable iff (srst)
      compare_irq_req == (compare_flag_r && compare_irq_enable_r &&
                          global_irq_enable);
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("compare irq request wrongly gated");
  property p_ack_clears;
    @(posedge clk) disable iff (srst)
      compare_irq_ack && !(timer_tick && match) |=> !compare_flag_r;
  endproperty
  a_ack_clears: assert property (p_ack_clears)
    else $error("interrupt entry did not clear flag");
  property p_block_after_write;
    @(posedge clk) disable iff (srst)
      wr_counter |=> !match;
  endproperty
  a_block_after_write: assert property (p_block_after_write)
    else $error("match seen right after counter write");
  property p_normal_wrap;
    @(posedge clk) disable iff (srst)
      timer_tick && !wr_counter && ctrl_r.mode == tcu_pkg::MODE_NORMAL &&
      counter_value_r == tcu_pkg::CNT_MAX
      |=> counter_value_r == tcu_pkg::CNT_BOTTOM && overflow_flag_r;
  endproperty
  a_normal_wrap: assert property (p_normal_wrap)
    else $error("normal mode wrap or overflow wrong");
  property p_ctc_clear;
    @(posedge clk) disable iff (srst)
      timer_tick && !wr_counter && match &&
      ctrl_r.mode == tcu_pkg::MODE_CLEAR_ON_MATCH
      |=> counter_value_r == tcu_pkg::CNT_BOTTOM;
  endproperty
  a_ctc_clear: assert property (p_ctc_clear)
    else $error("counter not cleared on match");
  property p_force_no_flag;
    @(posedge clk) disable iff (srst)
      force_compare_strobe && !timer_tick && !compare_flag_r
      |=> !compare_flag_r && $stable(counter_value_r);
  endproperty
  a_force_no_flag: assert property (p_force_no_flag)
    else $error("forced compare touched flag or counter");
  property p_action_none_holds;
    @(posedge clk) disable iff (srst)
      ctrl_r.action == tcu_pkg::ACT_NONE && !wr_control
      |=> $stable(compare_output_r);
  endproperty
  a_action_none_holds: assert property (p_action_none_holds)
    else $error("output register changed with action none");
  property p_pwm_buffered;
    @(posedge clk) disable iff (srst)
      is_pwm && !load_buffer && !wr_control |=> $stable(compare_value_r);
  endproperty
  a_pwm_buffered: assert property (p_pwm_buffered)
    else $error("active compare changed outside update point");
  property p_pin_override;
    @(posedge clk) disable iff (srst)
      pin_out == ((ctrl_r.action != tcu_pkg::ACT_NONE) ?
                  compare_output_r : port_value_r);
  endproperty
  a_pin_override: assert property (p_pin_override)
    else $error("pin source selection wrong");
endmodule

// File: rtl/tcu_pkg.sv
// Constants, types and register map of the timer compare output unit.
// Assumes one clock; the timer tick comes from clock-select logic on clk.
//
// What this block does
// - Compare counter with active compare continuously
// - Compare flag sets one timer tick later
// - Compare irq needs flag, enable, global enable
// - Interrupt entry clears compare flag
// - Writing one clears compare flag
// - Waveform from match, mode, action, extremes
// - PWM modes buffer compare, load at top/bottom
// - Normal and clear-on-match write compare directly
// - Buffered mode accesses go to buffer
// - Non-PWM force strobe acts like match on output, no flag
// - Counter write blocks next tick's match
// - Output register kept across mode changes
// - Action select unbuffered, applies next match
// - Reset clears output register to zero
// - Nonzero action overrides port, direction decides
// - Action zero leaves output register unchanged
// - Mode sets counting, action does not
// - Non-PWM set/clear/toggle; PWM picks polarity
// - Normal mode increments, wraps FF to 00
// - Overflow flag sets when counter wraps FF to 00 or counts down to zero, in fast PWM when it becomes FF
// - Mode 2 clears counter on match
// - Mode 3 single-slope fast PWM
// - Mode 1 dual-slope phase correct PWM
// - PWM action 2 normal, 3 inverted, 1 toggles in fast PWM only
package tcu_pkg;

  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [2:0] OFS_COUNTER = 3'h0;
  localparam logic [2:0] OFS_COMPARE = 3'h1;
  localparam logic [2:0] OFS_CONTROL = 3'h2;
  localparam logic [2:0] OFS_FLAGS = 3'h3;
  localparam logic [2:0] OFS_IRQ_EN = 3'h4;
  localparam logic [2:0] OFS_PIN = 3'h5;

  // Field positions
  localparam int CTL_MODE_LSB = 0;
  localparam int CTL_ACT_LSB = 4;
  localparam int CTL_FORCE_BIT = 7;
  localparam int FLG_OVF_BIT = 0;
  localparam int FLG_CMP_BIT = 1;
  localparam int PIN_PORT_BIT = 0;
  localparam int PIN_DIR_BIT = 1;

  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_STEP = 8'h01;
  localparam logic [7:0] REG_RESET = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Modes and actions
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_PHASE_PWM = 2'b01,
    MODE_CLEAR_ON_MATCH = 2'b10,
    MODE_FAST_PWM = 2'b11
  } tcu_mode_e;

  typedef enum logic [1:0] {
    ACT_NONE = 2'b00,
    ACT_TOGGLE = 2'b01,
    ACT_CLEAR = 2'b10,
    ACT_SET = 2'b11
  } tcu_act_e;

  typedef struct packed {
    tcu_act_e action;
    tcu_mode_e mode;
  } tcu_ctrl_s;

  localparam tcu_ctrl_s CTRL_RESET = '{action: ACT_NONE, mode: MODE_NORMAL};

endpackage

// File: dv/tcu_pin_load.sv
// Model of the load that hangs on the compare output pin.
// Assumes pin_out and pin_oe come straight from the compare unit.
module tcu_pin_load (
  // Pin from the unit
  input wire logic pin_out,
  input wire logic pin_oe,
  // Level seen by the load
  output logic level
);
  timeunit 1ns;
  timeprecision 1ps;

  // A released pin sinks through a pull-down, so a stale value never shows
  assign level = pin_oe ? pin_out : 1'b0;
endmodule

// File: dv/tcu_compare_unit_tb_top.sv
// Self-checking bench of the timer compare output unit.
// Assumes a 200 MHz clk, a pulled-down pin load and a register port
// that answers reads one cycle after the strobe.
module tcu_compare_unit_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [2:0] A_CNT = tcu_pkg::OFS_COUNTER;
  localparam logic [2:0] A_CMP = tcu_pkg::OFS_COMPARE;
  localparam logic [2:0] A_CTL = tcu_pkg::OFS_CONTROL;
  localparam logic [2:0] A_FLG = tcu_pkg::OFS_FLAGS;
  localparam logic [2:0] A_IEN = tcu_pkg::OFS_IRQ_EN;
  localparam logic [2:0] A_PIN = tcu_pkg::OFS_PIN;
  localparam logic [1:0] NRM = tcu_pkg::MODE_NORMAL;
  localparam logic [1:0] PPW = tcu_pkg::MODE_PHASE_PWM;
  localparam logic [1:0] CMM = tcu_pkg::MODE_CLEAR_ON_MATCH;
  localparam logic [1:0] FPW = tcu_pkg::MODE_FAST_PWM;
  localparam logic [1:0] NON = tcu_pkg::ACT_NONE;
  localparam logic [1:0] TGL = tcu_pkg::ACT_TOGGLE;
  localparam logic [1:0] CLR = tcu_pkg::ACT_CLEAR;
  localparam logic [1:0] SET = tcu_pkg::ACT_SET;

  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic timer_tick = 1'b0;
  logic global_irq_enable = 1'b0;
  logic compare_irq_ack = 1'b0;
  logic overflow_irq_ack = 1'b0;
  logic [7:0] rdata;
  logic compare_irq_req;
  logic overflow_irq_req;
  logic pin_out;
  logic pin_oe;
  logic level;
  int err_total = 0;
  int checked = 0;

  always #2.5 clk = ~clk;

  tcu_compare_unit dut_u (
    .clk, .srst, .addr, .wdata, .wr_stb, .rd_stb, .rdata, .timer_tick,
    .global_irq_enable, .compare_irq_ack, .overflow_irq_ack,
    .compare_irq_req, .overflow_irq_req, .pin_out, .pin_oe
  );

  tcu_pin_load load_u (.pin_out, .pin_oe, .level);

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk8(input string n, input logic [7:0] e,
                      input logic [7:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk1(input string n, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %b seen %b", n, e, g);
    end
  endtask

  // Every driver ends 1 ns past the edge so registered results have landed
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
    #1;
  endtask

  task automatic rdc(input string n, input logic [2:0] a,
                     input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1;
    chk8(n, e, rdata);
  endtask

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk);
      timer_tick <= 1'b1;
      @(posedge clk);
      timer_tick <= 1'b0;
      #1;
    end
  endtask

  task automatic ctl(input logic [1:0] m, a, input logic f);
    wr(A_CTL, {f, 1'b0, a, 2'h0, m});
  endtask

  // Counter lands on c at the first tick, the match fires on the second
  task automatic mt(input logic [7:0] c);
    wr(A_CNT, c - 8'h01);
    tick(2);
  endtask

  task automatic ack(input logic ovf);
    @(posedge clk);
    compare_irq_ack <= !ovf;
    overflow_irq_ack <= ovf;
    @(posedge clk);
    compare_irq_ack <= 1'b0;
    overflow_irq_ack <= 1'b0;
    #1;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk1("pin out", 1'b0, pin_out);
    chk1("pin drive", 1'b0, pin_oe);
    for (int i = 0; i < 8; i++) begin
      rdc("reset value", 3'(i), 8'h00);
    end
  endtask

  // Output state is set by a forced compare before the pin drives
  task automatic t_match();
    ctl(NRM, CLR, 1'b1);
    wr(A_PIN, 8'h02);
    wr(A_FLG, 8'h03);
    ctl(NRM, TGL, 1'b0);
    wr(A_CMP, 8'h05);
    wr(A_CNT, 8'h04);
    tick(1);
    rdc("flags", A_FLG, 8'h00);
    chk1("pin level", 1'b0, level);
    tick(1);
    rdc("flags", A_FLG, 8'h02);
    chk1("pin level", 1'b1, level);
    rdc("counter", A_CNT, 8'h06);
  endtask

  task automatic t_irq();
    wr(A_IEN, 8'h02);
    chk1("cmp irq", 1'b0, compare_irq_req);
    @(posedge clk);
    global_irq_enable <= 1'b1;
    #1;
    chk1("cmp irq", 1'b1, compare_irq_req);
    wr(A_FLG, 8'h00);
    chk1("cmp irq", 1'b1, compare_irq_req);
    ack(1'b0);
    chk1("cmp irq", 1'b0, compare_irq_req);
    mt(8'h05);
    chk1("cmp irq", 1'b1, compare_irq_req);
    wr(A_FLG, 8'h02);
    chk1("cmp irq", 1'b0, compare_irq_req);
  endtask

  task automatic t_force();
    logic [1:0] act [4] = '{SET, CLR, TGL, TGL};
    logic e [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    wr(A_PIN, 8'h03);
    for (int i = 0; i < 4; i++) begin
      ctl(NRM, act[i], 1'b1);
      chk1("forced pin", e[i], level);
    end
    rdc("control", A_CTL, {2'h0, TGL, 2'h0, NRM});
    rdc("flags", A_FLG, 8'h00);
    rdc("counter", A_CNT, 8'h06);
    ctl(NRM, NON, 1'b1);
    chk1("port pin", 1'b1, level);
    mt(8'h05);
    ctl(NRM, TGL, 1'b0);
    chk1("held pin", 1'b0, level);
  endtask

  // Blocking must survive idle cycles while the timer clock is stopped
  task automatic t_block();
    wr(A_FLG, 8'h03);
    wr(A_CMP, 8'h20);
    wr(A_CNT, 8'h20);
    repeat (3) @(posedge clk);
    tick(1);
    rdc("flags", A_FLG, 8'h00);
    rdc("counter", A_CNT, 8'h21);
  endtask

  task automatic t_ovf();
    wr(A_IEN, 8'h01);
    wr(A_CNT, 8'hFF);
    chk1("ovf irq", 1'b0, overflow_irq_req);
    tick(1);
    chk1("ovf irq", 1'b1, overflow_irq_req);
    rdc("counter", A_CNT, 8'h00);
    ack(1'b1);
    chk1("ovf irq", 1'b0, overflow_irq_req);
  endtask

  task automatic t_cmm();
    ctl(NRM, SET, 1'b1);
    ctl(CMM, TGL, 1'b0);
    chk1("mode change pin", 1'b1, level);
    wr(A_CMP, 8'h02);
    wr(A_CNT, 8'h00);
    tick(3);
    rdc("counter", A_CNT, 8'h00);
    chk1("toggled pin", 1'b0, level);
  endtask

  task automatic t_fast();
    ctl(NRM, SET, 1'b1);
    wr(A_CMP, 8'h10);
    ctl(FPW, CLR, 1'b0);
    chk1("mode change pin", 1'b1, level);
    wr(A_CMP, 8'h80);
    rdc("compare", A_CMP, 8'h80);
    wr(A_FLG, 8'h03);
    mt(8'h10);
    rdc("flags", A_FLG, 8'h02);
    chk1("pwm pin", 1'b0, level);
    wr(A_CNT, 8'hFE);
    tick(2);
    chk1("bottom pin", 1'b1, level);
    rdc("counter", A_CNT, 8'h00);
    wr(A_FLG, 8'h03);
    mt(8'h80);
    rdc("flags", A_FLG, 8'h02);
    chk1("pwm pin", 1'b0, level);
    ctl(FPW, SET, 1'b0);
    mt(8'h80);
    chk1("inverted pin", 1'b1, level);
  endtask

  task automatic t_phase();
    ctl(PPW, CLR, 1'b1);
    chk1("unforced pin", 1'b1, level);
    // Counter is loaded while counting up, never with bottom going down
    wr(A_CNT, 8'hFE);
    tick(2);
    rdc("counter", A_CNT, 8'hFE);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    if (err_total == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    #1;
    t_reset();
    t_match();
    t_irq();
    t_force();
    t_block();
    t_ovf();
    t_cmm();
    t_fast();
    t_phase();
    conclude();
  end

  // The tests need about one microsecond; this bound leaves a wide margin
  initial begin
    #50us;
    err_total++;
    conclude();
  end
endmodule
